// file: hw/bcl_defines.vh
/*
 * constants of the configuration loader: register offsets, field positions,
 * image addresses, signature and default values, timing figures.
 * assumes a 25 MHz core clock and a byte-addressed serial memory.
 */
`ifndef BCL_DEFINES_VH
`define BCL_DEFINES_VH
// ------------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------------
`define BCL_REG_CTRL     8'h00
`define BCL_REG_STATUS   8'h04
`define BCL_REG_CFG      8'h08
`define BCL_CTRL_RELOAD  0
`define BCL_CTRL_ADDR4   1
// ------------------------------------------------------------------
// configuration image
// ------------------------------------------------------------------
`define BCL_IMG_SIG0     4'h0
`define BCL_IMG_SIG1     4'h1
`define BCL_IMG_APM      4'h2
`define BCL_IMG_VSIG     4'h4
`define BCL_IMG_OPT      4'h5
`define BCL_IMG_LAST     4'h5
`define BCL_SIG0_VAL     8'h53
`define BCL_SIG1_VAL     8'h4B
`define BCL_DEF_APM      8'h00
`define BCL_DEF_VSIG     8'h24
`define BCL_DEF_OPT      8'h07
`define BCL_OPT_PAGE8    5
`define BCL_OPT_POLL     4
`define BCL_OPT_BUSYDLY  3
`define BCL_OPT_SHORTPKT 2
`define BCL_DEV_ADDR2    7'h52
`define BCL_DEV_ADDR4    7'h54
`define BCL_LOAD_MAX     32'h000000FF
// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define BCL_CLK_NS       40
`define BCL_QUARTER_NS   2500
`define BCL_BUSY_DLY_MS  120
`endif

// file: hw/bcl_loader.v
/*
 * configuration loader: fetches the configuration image from a serial
 * memory over a two-wire bus, checks the signature and drives the
 * settings into the bridge. assumes an APB master on pclk and external
 * pull-ups on both bus wires.
 */
// Overview of operation
// - memory at device address 2 or 4
// - byte zero must match first signature
// - byte one must match second signature
// - nonzero power value issues feature enable
// - zero power value suppresses the command
// - power value ignored for packet devices
// - matching command byte means vendor command
// - option bit 5 exposes page 8
// - option bit 4 selects status polling
// - option bit 3 enables 120 ms delay
// - option bit 2 forces short packet
// - load writes at most 255 bytes
`timescale 1ns/10ps
`default_nettype none
`include "bcl_defines.vh"
module bcl_loader #(
   parameter QTR_CYC = (`BCL_QUARTER_NS + `BCL_CLK_NS - 1) / `BCL_CLK_NS,
   parameter DLY_CYC = `BCL_BUSY_DLY_MS * 1000000 / `BCL_CLK_NS
) (
   input  wire        pclk,        // core clock
   input  wire        presetn,     // async reset, low
   input  wire        psel,        // apb select
   input  wire        penable,     // apb enable
   input  wire        pwrite,      // apb direction
   input  wire [7:0]  paddr,       // apb byte address
   input  wire [31:0] pwdata,      // apb write data
   output reg  [31:0] prdata,      // apb read data
   output reg         pready,      // apb ready
   output reg         pslverr,     // apb error
   input  wire        scl_i,       // clock wire level
   output reg         scl_o,       // clock drive value
   output reg         scl_oe,      // clock pulled low
   input  wire        sda_i,       // data wire level
   output reg         sda_o,       // data drive value
   output reg         sda_oe,      // data pulled low
   input  wire        drive_init,  // drive init step pulse
   input  wire        drive_has_apm,  // drive supports power mgmt
   input  wire        drive_is_atapi, // attached device is packet type
   output reg         drive_auto_power_mgmt, // issue feature enable
   output reg  [7:0]  apm_value,   // value for feature enable
   input  wire        cbw_valid,   // command block byte 0 valid
   input  wire [7:0]  cbw_byte0,   // command block byte 0
   output reg         vendor_cmd,  // decode as vendor command
   output reg  [7:0]  vendor_command_signature, // stored signature
   output reg         expose_page8, // report caching page
   output reg         poll_status, // poll instead of interrupt
   input  wire        drive_interrupt_request, // drive irq pin
   input  wire        status_valid, // status register sample valid
   input  wire        status_busy, // busy bit of that sample
   output reg         cmd_complete, // drive command finished
   input  wire        drive_data_request_bit, // data request read
   input  wire        len_mismatch, // device and host lengths differ
   output reg         busy_wait,   // hold off status evaluation
   output reg         short_pkt,   // short packet before stall
   input  wire        load_req,    // vendor load command seen
   input  wire [31:0] load_len,    // its transfer length
   input  wire [15:0] load_start,  // its start address
   output reg         load_ok      // load accepted
);
// ------------------------------------------------------------------
// bus engine states
// ------------------------------------------------------------------
localparam S_IDLE = 4'h1;
localparam S_STRT = 4'h2;
localparam S_BIT  = 4'h4;
localparam S_STOP = 4'h8;
localparam T_RD0  = 4'h5;
localparam T_STOP = 4'hB;

reg  [1:0]  scl_s_r, sda_s_r, irq_s_r;
reg  [3:0]  st_r;
reg  [1:0]  ph_r;
reg  [3:0]  bit_r;
reg  [3:0]  tok_r;
reg  [8:0]  sh_r;
reg  [15:0] qcnt_r;
reg         addr4_r, run_r, done_r, sig_ok_r, nack_r, reload_r;
reg  [7:0]  sig0_r, sig1_r, apm_img_r, vsig_img_r, opt_img_r;
reg  [7:0]  opt_r;
reg  [31:0] dcnt_r;
wire        tick = (qcnt_r == 16'h0000);
wire [6:0]  dev  = addr4_r ? `BCL_DEV_ADDR4 : `BCL_DEV_ADDR2;
wire [3:0]  img  = tok_r - T_RD0;
wire        sig_good = (sig0_r == `BCL_SIG0_VAL) &&
                       (sig1_r == `BCL_SIG1_VAL);
reg  [8:0]  tok_sh;
reg         tok_start;

// ------------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      irq_s_r <= 2'h0;
   end
   else
   begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      irq_s_r <= {irq_s_r[0], drive_interrupt_request};
   end
end

// ------------------------------------------------------------------
// token sequence: start, dev write, word 0, restart, dev read, 6 reads
// ------------------------------------------------------------------
always @*
begin
   tok_start = (tok_r == 4'h0) || (tok_r == 4'h3);
   case (tok_r)
      4'h1:    tok_sh = {dev, 1'b0, 1'b1};
      4'h2:    tok_sh = 9'h001;           // word address zero
      4'h4:    tok_sh = {dev, 1'b1, 1'b1};
      4'hA:    tok_sh = 9'h1FF;           // last byte: no ack
      default: tok_sh = 9'h1FE;           // read, acknowledge
   endcase
end

// ------------------------------------------------------------------
// two-wire engine
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      st_r <= S_IDLE;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      tok_r <= 4'h0;
      sh_r <= 9'h000;
      qcnt_r <= 16'h0000;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      run_r <= 1'b1;
      done_r <= 1'b0;
      nack_r <= 1'b0;
      sig0_r <= 8'h00;
      sig1_r <= 8'h00;
      apm_img_r <= 8'h00;
      vsig_img_r <= 8'h00;
      opt_img_r <= 8'h00;
   end
   else
   begin
      qcnt_r <= tick ? QTR_CYC[15:0] - 16'h0001 : qcnt_r - 16'h0001;
      if (reload_r && !run_r)
      begin
         run_r <= 1'b1;
         done_r <= 1'b0;
         nack_r <= 1'b0;
         tok_r <= 4'h0;
      end
      case (st_r)
         S_IDLE:
            if (run_r && tick)
            begin
               st_r <= tok_start ? S_STRT : S_BIT;
               sh_r <= tok_sh;
               ph_r <= 2'h0;
               bit_r <= 4'h0;
            end
         S_STRT:
            if (tick)
            begin
               ph_r <= ph_r + 2'h1;
               case (ph_r)
                  2'h0:
                  begin
                     sda_oe <= 1'b0;
                     scl_oe <= 1'b0;
                  end
                  2'h1: sda_oe <= 1'b1;
                  2'h2: scl_oe <= 1'b1;
                  default:
                  begin
                     tok_r <= tok_r + 4'h1;
                     st_r <= S_IDLE;
                  end
               endcase
            end
         S_BIT:
            if (tick)
            begin
               ph_r <= ph_r + 2'h1;
               case (ph_r)
                  2'h0: sda_oe <= ~sh_r[8];
                  2'h1: scl_oe <= 1'b0;
                  2'h2: sh_r <= {sh_r[7:0], sda_s_r[1]};
                  default:
                  begin
                     scl_oe <= 1'b1;
                     bit_r <= bit_r + 4'h1;
                     if (bit_r == 4'h8)
                     begin
                        // ack is let go at the next bit, not as clock falls
                        tok_r <= tok_r + 4'h1;
                        st_r <= S_IDLE;
                        if (tok_r < T_RD0 && sh_r[0])
                        begin
                           nack_r <= 1'b1;
                           tok_r <= T_STOP;
                        end
                        if (tok_r >= T_RD0)
                           case (img)
                              `BCL_IMG_SIG0: sig0_r <= sh_r[8:1];
                              `BCL_IMG_SIG1: sig1_r <= sh_r[8:1];
                              `BCL_IMG_APM:  apm_img_r <= sh_r[8:1];
                              `BCL_IMG_VSIG: vsig_img_r <= sh_r[8:1];
                              `BCL_IMG_OPT:  opt_img_r <= sh_r[8:1];
                              default: ;
                           endcase
                        if (tok_r == T_STOP - 4'h1)
                           st_r <= S_STOP;
                     end
                  end
               endcase
            end
         S_STOP:
            if (tick)
            begin
               ph_r <= ph_r + 2'h1;
               case (ph_r)
                  2'h0: sda_oe <= 1'b1;
                  2'h1: scl_oe <= 1'b0;
                  2'h2: sda_oe <= 1'b0;
                  default:
                  begin
                     st_r <= S_IDLE;
                     run_r <= 1'b0;
                     done_r <= 1'b1;
                  end
               endcase
            end
         default: st_r <= S_IDLE;
      endcase
      if (st_r == S_IDLE && run_r && tok_r == T_STOP && tick)
      begin
         st_r <= S_STOP;
         ph_r <= 2'h0;
      end
   end
end

// ------------------------------------------------------------------
// apply settings once the image is in
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      sig_ok_r <= 1'b0;
      apm_value <= `BCL_DEF_APM;
      vendor_command_signature <= `BCL_DEF_VSIG;
      opt_r <= `BCL_DEF_OPT;
   end
   else if (done_r && run_r == 1'b0 && st_r == S_IDLE)
   begin
      sig_ok_r <= sig_good && !nack_r;
      if (sig_good && !nack_r)
      begin
         apm_value <= apm_img_r;
         vendor_command_signature <= vsig_img_r;
         opt_r <= opt_img_r;
      end
      else
      begin
         apm_value <= `BCL_DEF_APM;
         vendor_command_signature <= `BCL_DEF_VSIG;
         opt_r <= `BCL_DEF_OPT;
      end
   end
end

// ------------------------------------------------------------------
// bridge behaviour
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      drive_auto_power_mgmt <= 1'b0;
      vendor_cmd <= 1'b0;
      expose_page8 <= 1'b0;
      poll_status <= 1'b0;
      short_pkt <= 1'b0;
      cmd_complete <= 1'b0;
      busy_wait <= 1'b0;
      dcnt_r <= 32'h00000000;
      load_ok <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
   end
   else
   begin
      drive_auto_power_mgmt <= drive_init && drive_has_apm
         && (apm_value != 8'h00)
         && !drive_is_atapi;
      vendor_cmd <= cbw_valid &&
         (cbw_byte0 == vendor_command_signature);
      expose_page8 <= opt_r[`BCL_OPT_PAGE8];
      poll_status <= opt_r[`BCL_OPT_POLL];
      short_pkt <= opt_r[`BCL_OPT_SHORTPKT];
      cmd_complete <= opt_r[`BCL_OPT_POLL] ?
         (status_valid && !status_busy) : irq_s_r[1];
      if (busy_wait)
      begin
         dcnt_r <= dcnt_r - 32'h00000001;
         if (dcnt_r == 32'h00000001 ||
             (status_valid && !status_busy))
            busy_wait <= 1'b0;
      end
      else if (drive_data_request_bit && len_mismatch &&
               opt_r[`BCL_OPT_BUSYDLY])
      begin
         busy_wait <= 1'b1;
         dcnt_r <= DLY_CYC[31:0];
      end
      load_ok <= load_req && (load_len <= `BCL_LOAD_MAX) &&
         (load_start == 16'h0000);
   end
end

// ------------------------------------------------------------------
// apb slave, no wait states
// ------------------------------------------------------------------
wire map_ok = (paddr == `BCL_REG_CTRL) || (paddr == `BCL_REG_STATUS) ||
              (paddr == `BCL_REG_CFG);
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      addr4_r <= 1'b0;
      reload_r <= 1'b0;
   end
   else
   begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !map_ok;
      reload_r <= 1'b0;
      if (psel && !penable && !pwrite)
         case (paddr)
            `BCL_REG_CTRL:   prdata <= {30'h0, addr4_r, run_r};
            `BCL_REG_STATUS: prdata <= {28'h0, nack_r, sig_ok_r,
                                        done_r, run_r};
            `BCL_REG_CFG:    prdata <= {8'h00, opt_r,
                                        vendor_command_signature,
                                        apm_value};
            default:         prdata <= 32'h00000000;
         endcase
      if (psel && penable && pready && pwrite &&
          paddr == `BCL_REG_CTRL)
      begin
         addr4_r <= pwdata[`BCL_CTRL_ADDR4];
         reload_r <= pwdata[`BCL_CTRL_RELOAD];
      end
   end
end
endmodule // bcl_loader
`default_nettype wire

// file: tb/bcl_eeprom.sv
/* behavioural serial memory holding the configuration image.
   assumes open-drain wires whose pull-ups the bench resolves. */
`timescale 1ns/10ps
`default_nettype none
module bcl_eeprom (
   input  wire logic       scl,  // clock wire
   input  wire logic       sda,  // data wire
   input  wire logic [6:0] dev,  // strapped address
   output var  logic       pull  // high pulls data low
);
   logic [7:0] mem [0:255];
   logic [7:0] sh, ptr;
   logic       act, rd, first, ok;
   int         cnt;
   initial
   begin
      foreach (mem[i]) mem[i] = 8'hFF;
      {pull, act, rd, first, ok, sh, ptr} = '0;
      cnt = 8;
   end
   // start or stop: data moves while the clock is high
   always @(sda)
      if (scl === 1'b1)
      begin
         act = !sda;
         first = 1;
         rd = 0;
         cnt = 8;
      end
   always @(posedge scl)
      if (act && !rd)
         sh = {sh[6:0], sda};
      else if (cnt == 8 && sda)
         act = 0;
   always @(negedge scl)
      if (act)
      begin
         cnt = (cnt == 8) ? 0 : cnt + 1;
         pull = 0;
         if (cnt == 8 && !rd)
         begin
            if (first)
            begin
               ok = (sh[7:1] == dev);
               rd = sh[0];
            end
            else if (ok)
               ptr = sh;
            first = 0;
            pull = ok;
         end
         else if (rd && ok && cnt < 8)
         begin
            if (cnt == 0)
            begin
               sh = mem[ptr];
               ptr = ptr + 8'h01;
            end
            pull = !sh[7 - cnt];
         end
      end
endmodule // bcl_eeprom
`default_nettype wire

// file: tb/bcl_loader_sva.sv
/* checker of the loader's drive-side outputs against their causes.
   assumes binding into bcl_loader on pclk and presetn. */
`timescale 1ns/10ps
`default_nettype none
module bcl_loader_chk #(
   parameter DLY_CYC = 20
) (
   input wire logic        pclk,           // clock
   input wire logic        presetn,        // reset, low
   input wire logic        drive_init,     // init step
   input wire logic        drive_has_apm,  // power able
   input wire logic        drive_is_atapi, // packet device
   input wire logic        drive_auto_power_mgmt, // enable
   input wire logic [7:0]  apm_value,      // power value
   input wire logic        cbw_valid,      // byte valid
   input wire logic [7:0]  cbw_byte0,      // block byte
   input wire logic        vendor_cmd,     // vendor decode
   input wire logic [7:0]  vendor_command_signature, // sig
   input wire logic        poll_status,    // polling
   input wire logic        drive_interrupt_request, // irq
   input wire logic        cmd_complete,   // done
   input wire logic        drive_data_request_bit, // dreq
   input wire logic        len_mismatch,   // lengths differ
   input wire logic        busy_wait,      // hold off
   input wire logic        load_req,       // load command
   input wire logic [31:0] load_len,       // its length
   input wire logic [15:0] load_start,     // its start
   input wire logic        load_ok         // accepted
);
   logic [31:0] busy_cnt_r;
   default clocking dclk @(posedge pclk); endclocking
   default disable iff (!presetn);
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         busy_cnt_r <= 32'h00000000;
      else
         busy_cnt_r <= busy_wait ? busy_cnt_r + 32'h00000001 : 32'h00000000;
   apm_issue_a:
      assert property (drive_init && drive_has_apm && !drive_is_atapi &&
      apm_value != 8'h00 |=> drive_auto_power_mgmt) else $error("no enable");
   apm_zero_a:
      assert property (drive_init && apm_value == 8'h00
      |=> !drive_auto_power_mgmt) else $error("enable on zero");
   apm_packet_a:
      assert property (drive_init && drive_is_atapi
      |=> !drive_auto_power_mgmt) else $error("enable on packet");
   vendor_decode_a:
      assert property (cbw_valid |=> vendor_cmd ==
      $past(cbw_byte0 == vendor_command_signature)) else $error("decode");
   irq_done_a:
      assert property ((!poll_status && drive_interrupt_request)[*4]
      |=> cmd_complete) else $error("irq lost");
   irq_idle_a:
      assert property ((!poll_status && !drive_interrupt_request)[*4]
      |=> !cmd_complete) else $error("false done");
   busy_cause_a:
      assert property ($rose(busy_wait) |->
      $past(drive_data_request_bit && len_mismatch)) else $error("busy");
   busy_cap_a:
      assert property (busy_cnt_r <= DLY_CYC + 1) else $error("busy long");
   load_len_a:
      assert property (load_req |=> load_ok == $past(load_len <=
      32'h000000FF && load_start == 16'h0000)) else $error("load");
endmodule // bcl_loader_chk
bind bcl_loader bcl_loader_chk #(.DLY_CYC(DLY_CYC)) chk_i (.pclk, .presetn,
   .drive_init, .drive_has_apm, .drive_is_atapi, .drive_auto_power_mgmt,
   .apm_value, .cbw_valid, .cbw_byte0, .vendor_cmd,
   .vendor_command_signature, .poll_status, .drive_interrupt_request,
   .cmd_complete, .drive_data_request_bit, .len_mismatch, .busy_wait,
   .load_req, .load_len, .load_start, .load_ok);
`default_nettype wire

// file: tb/bcl_loader_tb.sv
/* bench of the configuration loader: apb tasks, memory model, checks.
   assumes bcl_loader, bcl_eeprom and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`include "bcl_defines.vh"
module bcl_loader_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr, cbw_byte0, apm_value, vendor_command_signature;
   logic [31:0] pwdata, prdata, rd, load_len;
   logic [15:0] load_start;
   logic [6:0]  dev;
   logic        scl_oe, sda_oe, pull, drive_init, drive_has_apm;
   logic        drive_is_atapi, drive_auto_power_mgmt, cbw_valid;
   logic        vendor_cmd, expose_page8, poll_status, cmd_complete;
   logic        drive_interrupt_request, status_valid, status_busy;
   logic        drive_data_request_bit, len_mismatch, busy_wait;
   logic        short_pkt, load_req, load_ok;
   logic        scl_o, sda_o;
   int          fails, checks;
   wire         scl = !scl_oe;
   wire         sda = !(sda_oe || pull);
   bcl_loader #(.QTR_CYC(2), .DLY_CYC(20)) dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe,
      .drive_init, .drive_has_apm, .drive_is_atapi, .drive_auto_power_mgmt,
      .apm_value, .cbw_valid, .cbw_byte0, .vendor_cmd,
      .vendor_command_signature, .expose_page8, .poll_status,
      .drive_interrupt_request, .status_valid, .status_busy, .cmd_complete,
      .drive_data_request_bit, .len_mismatch, .busy_wait, .short_pkt,
      .load_req, .load_len, .load_start, .load_ok);
   bcl_eeprom eep (.scl, .sda, .dev, .pull);
   task automatic chk(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
      int n;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1;
      for (n = 0; n < 50 && pready !== 1'b1; n++)
         @(posedge pclk);
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge pclk);
      if (n == 50)
         fails++;
   endtask
   task automatic load(input logic w, logic [31:0] c);
      if (w)
         apb(1, `BCL_REG_CTRL, c);
      for (int n = 0; n < 2000; n++)
      begin
         apb(0, `BCL_REG_STATUS, 0);
         if (rd[0] === 1'b0)
            break;
      end
      if (rd[0] !== 1'b0)
         fails++;
      repeat (4) @(posedge pclk);
   endtask
   task automatic res(input logic [31:0] st, cf, input logic [2:0] lv);
      apb(0, `BCL_REG_STATUS, 0);
      chk(rd, st);
      apb(0, `BCL_REG_CFG, 0);
      chk(rd, cf);
      chk(32'({expose_page8, poll_status, short_pkt}), 32'(lv));
      chk(32'({vendor_command_signature, apm_value}), 32'(cf[15:0]));
   endtask
   task automatic img(input logic [47:0] v);
      for (int i = 0; i < 6; i++)
         eep.mem[i] = v[47 - 8 * i -: 8];
   endtask
   // one strobe pulse, then the answering output one cycle on
   task automatic pk(input logic [1:0] k, input logic e);
      case (k)
         2'd0: drive_init <= 1;
         2'd1: cbw_valid <= 1;
         default: load_req <= 1;
      endcase
      @(posedge pclk);
      {drive_init, cbw_valid, load_req} <= 3'b000;
      @(negedge pclk);
      chk(32'(k == 0 ? drive_auto_power_mgmt : k == 1 ? vendor_cmd :
         load_ok), 32'(e));
      @(posedge pclk);
   endtask
   // hold-off length in cycles, counted on the falling edge
   task automatic bw(input logic e);
      int n;
      {len_mismatch, drive_data_request_bit} <= 2'b11;
      @(posedge pclk);
      drive_data_request_bit <= 0;
      for (n = 0; n < 40; n++)
      begin
         @(negedge pclk);
         if (busy_wait !== 1'b1)
            break;
      end
      chk(n, e ? 20 : 0);
      @(posedge pclk);
      len_mismatch <= 0;
   endtask
   initial
   begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end
   initial
   begin
      repeat (60000) @(posedge pclk);
      fails++;
      close_out;
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, cbw_byte0, load_len} = '0;
      {load_start, drive_init, drive_has_apm, drive_is_atapi} = '0;
      {cbw_valid, drive_interrupt_request, status_valid, status_busy} = '0;
      {drive_data_request_bit, len_mismatch, load_req, fails, checks} = '0;
      {presetn, dev} = {1'b0, 7'h54};
      img(48'h534BA500C338);
      repeat (10) @(posedge pclk);
      presetn <= 1;
      load(0, 0);
      res(32'h0000000A, 32'h00072400, 3'b001);
      apb(0, 8'h0C, 0);
      chk({er, rd[30:0]}, 32'h80000000);
      chk(32'({scl_o, sda_o}), 0);
      $display("test missing part done");
      load(1, 32'h00000003);
      res(32'h00000006, 32'h0038C3A5, 3'b110);
      drive_has_apm <= 1;
      pk(0, 1);
      drive_is_atapi <= 1;
      pk(0, 0);
      {drive_is_atapi, cbw_byte0} <= {1'b0, 8'hC3};
      pk(1, 1);
      cbw_byte0 <= 8'h24;
      pk(1, 0);
      drive_interrupt_request <= 1;
      repeat (6) @(posedge pclk);
      @(negedge pclk) chk(32'(cmd_complete), 0);
      @(posedge pclk);
      status_valid <= 1;
      repeat (2) @(posedge pclk);
      @(negedge pclk) chk(32'(cmd_complete), 1);
      @(posedge pclk);
      {drive_interrupt_request, status_valid} <= 2'b00;
      bw(1);
      $display("test image at four done");
      dev = 7'h52;
      img(48'h534B00005A04);
      load(1, 32'h00000001);
      res(32'h00000006, 32'h00045A00, 3'b001);
      pk(0, 0);
      drive_interrupt_request <= 1;
      repeat (6) @(posedge pclk);
      @(negedge pclk) chk(32'(cmd_complete), 1);
      @(posedge pclk);
      drive_interrupt_request <= 0;
      bw(0);
      $display("test image at two done");
      for (int k = 0; k < 2; k++)
      begin
         img(k == 0 ? 48'h544BA500C338 : 48'h534AA500C338);
         load(1, 32'h00000001);
         res(32'h00000002, 32'h00072400, 3'b001);
      end
      $display("test signature done");
      load_len <= 32'h000000FF;
      pk(2, 1);
      load_len <= 32'h00000100;
      pk(2, 0);
      {load_len, load_start} <= {32'h000000FF, 16'h0001};
      pk(2, 0);
      $display("test load length done");
      close_out;
   end
endmodule // bcl_loader_tb
`default_nettype wire
